// >>> dbsr_ctrl.sv
// Host-side command controller that keeps bank-state command legality
`timescale 1ns/1ns
// What this block does
// - Rules hold with clock enable high
// - Never send unlisted state or command sequences
// - No same-bank command during transient states
// - Refresh, mode access, precharge-all: only NOP
// - Precharge of idle bank still costs period
// - Only NOP to bank in auto-precharge burst
// - Write only after read burst ends
// - Read only after write burst ends
// - All-bank refresh and mode write need every bank idle; precharge-all needs each bank idle or active
// - Other banks accept access during busy bank, unless it is refreshing or bursting the opposite way
// - Reset sent only as mode-register write
module dbsr_ctrl
#(
    parameter int unsigned INIT_CYCLES = 20000
)
(
    input  wire logic                          clk_i,
    input  wire logic                          srst_i,
    input  wire logic                          req_valid_i,
    input  wire dbsr_pkg::dbsr_cmd_t           req_cmd_i,
    input  wire logic [dbsr_pkg::BANK_W-1:0]   req_bank_i,
    input  wire logic                          req_ap_i,
    input  wire logic [dbsr_pkg::ADDR_W-1:0]   req_addr_i,
    input  wire logic [dbsr_pkg::CFG_W-1:0]    cfg_precharge_period_i,
    input  wire logic [dbsr_pkg::CFG_W-1:0]    cfg_activate_to_access_delay_i,
    input  wire logic [dbsr_pkg::CFG_W-1:0]    cfg_bank_refresh_period_i,
    input  wire logic [dbsr_pkg::CFG_W-1:0]    cfg_all_bank_refresh_period_i,
    input  wire logic [dbsr_pkg::CFG_W-1:0]    cfg_mode_read_period_i,
    input  wire logic [dbsr_pkg::CFG_W-1:0]    cfg_mode_write_period_i,
    input  wire logic [dbsr_pkg::CFG_W-1:0]    cfg_burst_cycles_i,
    output logic                               req_done_o,
    output logic                               req_refused_o,
    output logic                               init_done_o,
    output logic                               dev_cke_o,
    output dbsr_pkg::dbsr_cmd_t                dev_cmd_o,
    output logic [dbsr_pkg::BANK_W-1:0]        dev_bank_o,
    output logic                               dev_ap_o,
    output logic [dbsr_pkg::ADDR_W-1:0]        dev_addr_o
);

    typedef enum logic [1:0] {
        G_POWER_ON,
        G_RESETTING,
        G_READY,
        G_HOLD
    } dbsr_glob_t;

    localparam logic [dbsr_pkg::GCNT_W-1:0] INIT_LOAD =
        dbsr_pkg::GCNT_W'(INIT_CYCLES);

    dbsr_glob_t                          g_state;
    dbsr_glob_t                          next_g_state;
    logic [dbsr_pkg::GCNT_W-1:0]         gcnt;
    logic [dbsr_pkg::GCNT_W-1:0]         next_gcnt;
    logic [dbsr_pkg::BANK_W-1:0]         last_bank;
    dbsr_pkg::dbsr_bank_t                bank_st [dbsr_pkg::NUM_BANKS];
    logic [dbsr_pkg::NUM_BANKS-1:0]      b_idle;
    logic [dbsr_pkg::NUM_BANKS-1:0]      b_pre_ok;
    logic [dbsr_pkg::NUM_BANKS-1:0]      b_rd;
    logic [dbsr_pkg::NUM_BANKS-1:0]      b_wr;
    logic [dbsr_pkg::NUM_BANKS-1:0]      b_mrr_ok;
    logic [dbsr_pkg::NUM_BANKS-1:0]      b_refresh;
    logic [dbsr_pkg::NUM_BANKS-1:0]      hit;
    logic [dbsr_pkg::NUM_BANKS-1:0]      bst_hit;
    dbsr_pkg::dbsr_bank_t                sel_st;
    dbsr_pkg::dbsr_bank_t                last_st;
    logic                                all_idle;
    logic                                legal;
    logic                                legal_ready;
    logic                                want;
    logic                                issue;
    logic                                issue_reset;
    logic                                mrw_met;
    logic                                per_bank_cmd;
    logic [dbsr_pkg::GCNT_W-1:0]         hold_load;
    dbsr_pkg::dbsr_cmd_t                 next_cmd;
    logic [dbsr_pkg::ADDR_W-1:0]         next_addr;

    // Burst under way in a bank, with or without auto precharge
    function automatic logic in_burst(input dbsr_pkg::dbsr_bank_t s);
        in_burst = (s == dbsr_pkg::B_READING || s == dbsr_pkg::B_WRITING ||
                    s == dbsr_pkg::B_RD_AP || s == dbsr_pkg::B_WR_AP);
    endfunction

    ////////////////////////////////////////////////////////////////////////
    // Per-bank trackers and their state summaries
    for (genvar g = 0; g < dbsr_pkg::NUM_BANKS; g++)
    begin : g_bank
        assign hit[g]     = issue && (req_cmd_i == dbsr_pkg::CMD_PREA ||
                            (per_bank_cmd && req_bank_i == g));
        assign bst_hit[g] = issue && req_cmd_i == dbsr_pkg::CMD_BST &&
                            last_bank == g;
        assign b_idle[g]  = bank_st[g] == dbsr_pkg::B_IDLE;
        assign b_pre_ok[g] = b_idle[g] || bank_st[g] == dbsr_pkg::B_ACTIVE;
        assign b_rd[g]    = bank_st[g] == dbsr_pkg::B_READING ||
                            bank_st[g] == dbsr_pkg::B_RD_AP;
        assign b_wr[g]    = bank_st[g] == dbsr_pkg::B_WRITING ||
                            bank_st[g] == dbsr_pkg::B_WR_AP;
        assign b_mrr_ok[g] = !in_burst(bank_st[g]) &&
                             bank_st[g] != dbsr_pkg::B_REFRESHING;
        assign b_refresh[g] = bank_st[g] == dbsr_pkg::B_REFRESHING;

        dbsr_bank u_bank
        (
            .clk_i     (clk_i),
            .srst_i    (srst_i),
            .cmd_i     (req_cmd_i),
            .hit_i     (hit[g]),
            .ap_i      (req_ap_i),
            .bst_i     (bst_hit[g]),
            .t_rp_i    (cfg_precharge_period_i),
            .t_rcd_i   (cfg_activate_to_access_delay_i),
            .t_rfcpb_i (cfg_bank_refresh_period_i),
            .t_burst_i (cfg_burst_cycles_i),
            .state_o   (bank_st[g])
        );
    end

    ////////////////////////////////////////////////////////////////////////
    // Legality of the request against current bank states
    assign per_bank_cmd = req_cmd_i == dbsr_pkg::CMD_ACT ||
                          req_cmd_i == dbsr_pkg::CMD_RD ||
                          req_cmd_i == dbsr_pkg::CMD_WR ||
                          req_cmd_i == dbsr_pkg::CMD_PRE ||
                          req_cmd_i == dbsr_pkg::CMD_REFPB;
    assign sel_st   = bank_st[req_bank_i];
    assign last_st  = bank_st[last_bank];
    assign all_idle = &b_idle;

    // Transient banks fail their own checks; other banks stay open unless one is refreshing or bursting the opposite way
    always_comb
    begin
        legal_ready = 1'b0;
        unique case (req_cmd_i)
            dbsr_pkg::CMD_ACT:
                legal_ready = sel_st == dbsr_pkg::B_IDLE;
            dbsr_pkg::CMD_RD:
                legal_ready = (sel_st == dbsr_pkg::B_ACTIVE ||
                               sel_st == dbsr_pkg::B_READING) &&
                              !(|b_wr);
            dbsr_pkg::CMD_WR:
                legal_ready = (sel_st == dbsr_pkg::B_ACTIVE ||
                               sel_st == dbsr_pkg::B_WRITING) &&
                              !(|b_rd);
            dbsr_pkg::CMD_PRE:
                legal_ready = sel_st == dbsr_pkg::B_IDLE ||
                              sel_st == dbsr_pkg::B_ACTIVE;
            dbsr_pkg::CMD_PREA:
                legal_ready = &b_pre_ok;
            dbsr_pkg::CMD_REFPB:
                legal_ready = sel_st == dbsr_pkg::B_IDLE;
            dbsr_pkg::CMD_REFAB, dbsr_pkg::CMD_MRW:
                legal_ready = all_idle;
            dbsr_pkg::CMD_MRR:
                legal_ready = &b_mrr_ok;
            dbsr_pkg::CMD_BST:
                legal_ready = last_st == dbsr_pkg::B_READING ||
                              last_st == dbsr_pkg::B_WRITING;
            dbsr_pkg::CMD_NOP:
                legal_ready = 1'b0;
            default:
                legal_ready = 1'b0;
        endcase
    end

    // Auto-precharge bursts refuse own-bank commands
    // A refreshing bank blocks everything
    // Reset write still owns the device for its mode-write period
    assign mrw_met = (INIT_LOAD - gcnt) >
                     {8'h00, cfg_mode_write_period_i};
    assign legal = (g_state == G_READY && !(|b_refresh) && legal_ready) ||
                   (g_state == G_RESETTING && mrw_met &&
                    req_cmd_i == dbsr_pkg::CMD_MRR);
    assign want  = req_valid_i && req_cmd_i != dbsr_pkg::CMD_NOP;
    assign issue = want && legal;
    assign issue_reset = g_state == G_POWER_ON;

    ////////////////////////////////////////////////////////////////////////
    // Device-wide busy periods, counted from the issue edge plus one
    always_comb
    begin
        hold_load = dbsr_pkg::GCNT_ZERO;
        unique case (req_cmd_i)
            dbsr_pkg::CMD_REFAB:
                hold_load = {8'h00, cfg_all_bank_refresh_period_i};
            dbsr_pkg::CMD_MRW:
                hold_load = {8'h00, cfg_mode_write_period_i};
            dbsr_pkg::CMD_MRR:
                hold_load = {8'h00, cfg_mode_read_period_i};
            dbsr_pkg::CMD_PREA:
                hold_load = {8'h00, cfg_precharge_period_i};
            default:
                hold_load = dbsr_pkg::GCNT_ZERO;
        endcase
    end

    always_comb
    begin
        next_g_state = g_state;
        next_gcnt    = (gcnt == dbsr_pkg::GCNT_ZERO) ? gcnt
                                                     : gcnt - dbsr_pkg::GCNT_ONE;
        unique case (g_state)
            G_POWER_ON:
            begin
                next_g_state = G_RESETTING;
                next_gcnt    = INIT_LOAD;
            end
            G_RESETTING:
            begin
                // Mode read here ends in all-banks idle, not back in init
                if (issue)
                begin
                    next_g_state = G_HOLD;
                    next_gcnt    = hold_load + dbsr_pkg::GCNT_ONE;
                end
                else if (gcnt <= dbsr_pkg::GCNT_ONE)
                    next_g_state = G_READY;
            end
            G_READY:
            begin
                if (issue && hold_load != dbsr_pkg::GCNT_ZERO)
                begin
                    next_g_state = G_HOLD;
                    next_gcnt    = hold_load + dbsr_pkg::GCNT_ONE;
                end
            end
            G_HOLD:
            begin
                if (gcnt <= dbsr_pkg::GCNT_ONE)
                    next_g_state = G_READY;
            end
        endcase
    end

    assign next_cmd  = issue_reset ? dbsr_pkg::CMD_MRW :
                       issue       ? req_cmd_i : dbsr_pkg::CMD_NOP;
    assign next_addr = issue_reset ? {dbsr_pkg::MR_RESET_ADDR,
                                      dbsr_pkg::MR_RESET_DATA}
                                   : req_addr_i;

    ////////////////////////////////////////////////////////////////////////
    always_ff @(posedge clk_i)
    begin
        if (srst_i)
        begin
            g_state   <= G_POWER_ON;
            gcnt      <= dbsr_pkg::GCNT_ZERO;
            last_bank <= dbsr_pkg::BANK_ZERO;
        end
        else
        begin
            g_state <= next_g_state;
            gcnt    <= next_gcnt;
            if (issue && (req_cmd_i == dbsr_pkg::CMD_RD ||
                          req_cmd_i == dbsr_pkg::CMD_WR))
                last_bank <= req_bank_i;
        end
    end

    // Clock enable never drops: no power-down, so no exit wait applies
    always_ff @(posedge clk_i)
    begin
        if (srst_i)
        begin
            dev_cke_o     <= dbsr_pkg::CKE_ON;
            dev_cmd_o     <= dbsr_pkg::CMD_NOP;
            dev_bank_o    <= dbsr_pkg::BANK_ZERO;
            dev_ap_o      <= 1'b0;
            dev_addr_o    <= dbsr_pkg::ADDR_ZERO;
            req_done_o    <= 1'b0;
            req_refused_o <= 1'b0;
            init_done_o   <= 1'b0;
        end
        else
        begin
            dev_cke_o     <= dbsr_pkg::CKE_ON;
            dev_cmd_o     <= next_cmd;
            dev_bank_o    <= issue ? req_bank_i : dbsr_pkg::BANK_ZERO;
            dev_ap_o      <= issue && req_ap_i;
            dev_addr_o    <= (issue || issue_reset) ? next_addr
                                                    : dbsr_pkg::ADDR_ZERO;
            req_done_o    <= issue;
            req_refused_o <= want && !legal;
            init_done_o   <= next_g_state == G_READY;
        end
    end

endmodule

// >>> dbsr_pkg.sv
// Shared constants and types for the bank-state command controller
package dbsr_pkg;

    ////////////////////////////////////////////////////////////////////////
    // Sizes
    localparam int NUM_BANKS = 8;
    localparam int BANK_W    = 3;
    localparam int CFG_W     = 8;
    localparam int CNT_W     = 9;
    localparam int GCNT_W    = 16;
    localparam int ADDR_W    = 16;

    ////////////////////////////////////////////////////////////////////////
    // Mode-register reset command, carried as {address, data}
    localparam logic [7:0] MR_RESET_ADDR = 8'h3f;
    localparam logic [7:0] MR_RESET_DATA = 8'h00;

    ////////////////////////////////////////////////////////////////////////
    // Reset values and counter constants
    localparam logic              CKE_ON    = 1'b1;
    localparam logic [CNT_W-1:0]  CNT_ONE   = 9'h001;
    localparam logic [CNT_W-1:0]  CNT_ZERO  = 9'h000;
    localparam logic [GCNT_W-1:0] GCNT_ONE  = 16'h0001;
    localparam logic [GCNT_W-1:0] GCNT_ZERO = 16'h0000;
    localparam logic [ADDR_W-1:0] ADDR_ZERO = 16'h0000;
    localparam logic [BANK_W-1:0] BANK_ZERO = 3'h0;

    ////////////////////////////////////////////////////////////////////////
    // Commands on the command/address bus
    typedef enum logic [3:0] {
        CMD_NOP,
        CMD_ACT,
        CMD_RD,
        CMD_WR,
        CMD_PRE,
        CMD_PREA,
        CMD_REFPB,
        CMD_REFAB,
        CMD_MRW,
        CMD_MRR,
        CMD_BST
    } dbsr_cmd_t;

    // State of one bank as seen by the controller
    typedef enum logic [3:0] {
        B_IDLE,
        B_PRECHARGING,
        B_ACTIVATING,
        B_ACTIVE,
        B_READING,
        B_WRITING,
        B_RD_AP,
        B_WR_AP,
        B_REFRESHING
    } dbsr_bank_t;

endpackage

// >>> dbsr_bank.sv
// Per-bank state tracker with its own cycle counter
`timescale 1ns/1ns
module dbsr_bank
(
    input  wire logic                        clk_i,
    input  wire logic                        srst_i,
    input  wire dbsr_pkg::dbsr_cmd_t         cmd_i,
    input  wire logic                        hit_i,
    input  wire logic                        ap_i,
    input  wire logic                        bst_i,
    input  wire logic [dbsr_pkg::CFG_W-1:0]  t_rp_i,
    input  wire logic [dbsr_pkg::CFG_W-1:0]  t_rcd_i,
    input  wire logic [dbsr_pkg::CFG_W-1:0]  t_rfcpb_i,
    input  wire logic [dbsr_pkg::CFG_W-1:0]  t_burst_i,
    output dbsr_pkg::dbsr_bank_t             state_o
);

    dbsr_pkg::dbsr_bank_t             state;
    dbsr_pkg::dbsr_bank_t             next_state;
    logic [dbsr_pkg::CNT_W-1:0]       cnt;
    logic [dbsr_pkg::CNT_W-1:0]       next_cnt;
    logic [dbsr_pkg::CNT_W-1:0]       ld_rp;
    logic [dbsr_pkg::CNT_W-1:0]       ld_rcd;
    logic [dbsr_pkg::CNT_W-1:0]       ld_rfc;
    logic [dbsr_pkg::CNT_W-1:0]       ld_burst;
    logic [dbsr_pkg::CNT_W-1:0]       ld_burst_ap;
    logic                             done;

    // One extra cycle: the device registers the command an edge later
    assign ld_rp       = {1'b0, t_rp_i} + dbsr_pkg::CNT_ONE;
    assign ld_rcd      = {1'b0, t_rcd_i} + dbsr_pkg::CNT_ONE;
    assign ld_rfc      = {1'b0, t_rfcpb_i} + dbsr_pkg::CNT_ONE;
    assign ld_burst    = {1'b0, t_burst_i} + dbsr_pkg::CNT_ONE;
    assign ld_burst_ap = ld_burst + {1'b0, t_rp_i};
    assign done        = (cnt <= dbsr_pkg::CNT_ONE);
    assign state_o     = state;

    ////////////////////////////////////////////////////////////////////////
    always_comb
    begin
        next_state = state;
        next_cnt   = (cnt == dbsr_pkg::CNT_ZERO) ? cnt
                                                 : cnt - dbsr_pkg::CNT_ONE;
        unique case (state)
            dbsr_pkg::B_IDLE:
            begin
                if (hit_i && cmd_i == dbsr_pkg::CMD_ACT)
                begin
                    next_state = dbsr_pkg::B_ACTIVATING;
                    next_cnt   = ld_rcd;
                end
                else if (hit_i && (cmd_i == dbsr_pkg::CMD_PRE ||
                                   cmd_i == dbsr_pkg::CMD_PREA))
                begin
                    next_state = dbsr_pkg::B_PRECHARGING;
                    next_cnt   = ld_rp;
                end
                else if (hit_i && cmd_i == dbsr_pkg::CMD_REFPB)
                begin
                    next_state = dbsr_pkg::B_REFRESHING;
                    next_cnt   = ld_rfc;
                end
            end
            dbsr_pkg::B_ACTIVE, dbsr_pkg::B_READING, dbsr_pkg::B_WRITING:
            begin
                if (hit_i && (cmd_i == dbsr_pkg::CMD_RD ||
                              cmd_i == dbsr_pkg::CMD_WR))
                begin
                    if (ap_i)
                    begin
                        next_state = (cmd_i == dbsr_pkg::CMD_RD) ?
                                     dbsr_pkg::B_RD_AP : dbsr_pkg::B_WR_AP;
                        next_cnt   = ld_burst_ap;
                    end
                    else
                    begin
                        next_state = (cmd_i == dbsr_pkg::CMD_RD) ?
                                     dbsr_pkg::B_READING :
                                     dbsr_pkg::B_WRITING;
                        next_cnt   = ld_burst;
                    end
                end
                else if (hit_i && (cmd_i == dbsr_pkg::CMD_PRE ||
                                   cmd_i == dbsr_pkg::CMD_PREA))
                begin
                    next_state = dbsr_pkg::B_PRECHARGING;
                    next_cnt   = ld_rp;
                end
                else if (state != dbsr_pkg::B_ACTIVE && (bst_i || done))
                begin
                    next_state = dbsr_pkg::B_ACTIVE;
                end
            end
            dbsr_pkg::B_ACTIVATING:
            begin
                if (done)
                    next_state = dbsr_pkg::B_ACTIVE;
            end
            dbsr_pkg::B_PRECHARGING, dbsr_pkg::B_RD_AP,
            dbsr_pkg::B_WR_AP, dbsr_pkg::B_REFRESHING:
            begin
                if (done)
                    next_state = dbsr_pkg::B_IDLE;
            end
            default:
            begin
                next_state = dbsr_pkg::B_IDLE;
            end
        endcase
    end

    ////////////////////////////////////////////////////////////////////////
    always_ff @(posedge clk_i)
    begin
        if (srst_i)
        begin
            state <= dbsr_pkg::B_IDLE;
            cnt   <= dbsr_pkg::CNT_ZERO;
        end
        else
        begin
            state <= next_state;
            cnt   <= next_cnt;
        end
    end

endmodule

// >>> dbsr_ctrl_chk.sv
// Port-level assertions for the bank-state command controller
`timescale 1ns/1ns
module dbsr_ctrl_chk
(
    input wire logic                     clk_i,
    input wire logic                     srst_i,
    input wire logic                     req_valid_i,
    input wire dbsr_pkg::dbsr_cmd_t      req_cmd_i,
    input wire logic                     req_done_o,
    input wire logic                     req_refused_o,
    input wire logic                     init_done_o,
    input wire logic                     dev_cke_o,
    input wire dbsr_pkg::dbsr_cmd_t      dev_cmd_o,
    input wire logic [dbsr_pkg::BANK_W-1:0] dev_bank_o,
    input wire logic [dbsr_pkg::ADDR_W-1:0] dev_addr_o
);
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (srst_i);
    ////////////////////////////////////////////////////////////////////////
    property p_cke; dev_cke_o == 1'b1; endproperty
    a_cke: assert property (p_cke)
        else $error("clock enable low");
    property p_rst_mrw; $fell(srst_i) |-> ##[0:1]
        (dev_cmd_o == dbsr_pkg::CMD_MRW && dev_addr_o == 16'h3f00);
    endproperty
    a_rst_mrw: assert property (p_rst_mrw)
        else $error("no reset mode write");
    property p_answer; init_done_o && req_valid_i &&
        req_cmd_i != dbsr_pkg::CMD_NOP |=> req_done_o != req_refused_o;
    endproperty
    a_answer: assert property (p_answer)
        else $error("request not answered once");
    property p_ref_nop; req_refused_o |-> dev_cmd_o == dbsr_pkg::CMD_NOP;
    endproperty
    a_ref_nop: assert property (p_ref_nop)
        else $error("refused request reached bus");
    property p_not_rdy; !init_done_o && req_valid_i &&
        !(req_cmd_i inside {dbsr_pkg::CMD_NOP, dbsr_pkg::CMD_MRR})
        |=> req_refused_o; endproperty
    a_not_rdy: assert property (p_not_rdy)
        else $error("command accepted while resetting");
    property p_act_gap; dev_cmd_o == dbsr_pkg::CMD_ACT |=>
        !(dev_cmd_o inside {dbsr_pkg::CMD_RD, dbsr_pkg::CMD_WR} &&
        dev_bank_o == $past(dev_bank_o)); endproperty
    a_act_gap: assert property (p_act_gap)
        else $error("access inside activate delay");
    property p_pre_gap; dev_cmd_o == dbsr_pkg::CMD_PRE |=>
        !(dev_cmd_o == dbsr_pkg::CMD_ACT &&
        dev_bank_o == $past(dev_bank_o)); endproperty
    a_pre_gap: assert property (p_pre_gap)
        else $error("activate inside precharge period");
    property p_hold; dev_cmd_o inside {dbsr_pkg::CMD_MRW,
        dbsr_pkg::CMD_REFAB, dbsr_pkg::CMD_PREA} |=>
        (dev_cmd_o == dbsr_pkg::CMD_NOP) [*2]; endproperty
    a_hold: assert property (p_hold)
        else $error("command during device hold");
endmodule
bind dbsr_ctrl dbsr_ctrl_chk u_chk (.clk_i(clk_i), .srst_i(srst_i),
    .req_valid_i(req_valid_i), .req_cmd_i(req_cmd_i),
    .req_done_o(req_done_o), .req_refused_o(req_refused_o),
    .init_done_o(init_done_o), .dev_cke_o(dev_cke_o),
    .dev_cmd_o(dev_cmd_o), .dev_bank_o(dev_bank_o), .dev_addr_o(dev_addr_o));

// >>> dbsr_dev_model.sv
// Device model that counts commands sent into busy banks
`timescale 1ns/1ns
module dbsr_dev_model
#(
    parameter int T_RP   = 4,
    parameter int T_RCD  = 4,
    parameter int T_HOLD = 4,
    parameter int T_AP   = 12
)
(
    input  wire logic                     clk_i,
    input  wire logic                     srst_i,
    input  wire logic                     cke_i,
    input  wire dbsr_pkg::dbsr_cmd_t      cmd_i,
    input  wire logic [dbsr_pkg::BANK_W-1:0] bank_i,
    input  wire logic                     ap_i,
    output int                            viol_o
);
    int bank_busy [dbsr_pkg::NUM_BANKS];
    int dev_busy;
    // Busy windows start at the edge that registers the command
    always @(posedge clk_i)
    begin
        foreach (bank_busy[i]) if (bank_busy[i] > 0) bank_busy[i]--;
        if (dev_busy > 0) dev_busy--;
        if (srst_i)
        begin
            viol_o = 0;
            dev_busy = 0;
            foreach (bank_busy[i]) bank_busy[i] = 0;
        end
        else
        begin
            if (cke_i !== 1'b1) viol_o++;
            if (cmd_i != dbsr_pkg::CMD_NOP && (dev_busy > 0 ||
                bank_busy[bank_i] > 0)) viol_o++;
            case (cmd_i)
            dbsr_pkg::CMD_ACT: bank_busy[bank_i] = T_RCD;
            dbsr_pkg::CMD_PRE:
                bank_busy[bank_i] = T_RP;
            dbsr_pkg::CMD_RD, dbsr_pkg::CMD_WR:
                if (ap_i) bank_busy[bank_i] = T_AP;
            dbsr_pkg::CMD_MRW, dbsr_pkg::CMD_MRR, dbsr_pkg::CMD_REFAB,
            dbsr_pkg::CMD_PREA, dbsr_pkg::CMD_REFPB:
                dev_busy = T_HOLD;
            default: ;
            endcase
        end
    end
endmodule

// >>> dbsr_ctrl_bench.sv
// Self-checking bench for the bank-state command controller
`timescale 1ns/1ns
`define CHK(a, b) begin cmp_count++; if ((a) !== (b)) begin err_count++; \
    $display("unexpected %0t %h %h", $time, (a), (b)); end end
module dbsr_ctrl_bench;
    logic clk_i = 1'b0, srst_i = 1'b1, req_valid_i = 1'b0, req_ap_i = 1'b0;
    dbsr_pkg::dbsr_cmd_t req_cmd_i = dbsr_pkg::CMD_NOP, dev_cmd_o;
    logic [2:0] req_bank_i = 3'h0, dev_bank_o;
    logic [15:0] req_addr_i = 16'h0000, dev_addr_o;
    logic [7:0] t_short = 8'h04, t_burst = 8'h08;
    logic req_done_o, req_refused_o, init_done_o, dev_cke_o, dev_ap_o;
    int err_count = 0, cmp_count = 0, cycles = 0, viol;
    dbsr_ctrl #(.INIT_CYCLES(20)) DUT (.clk_i(clk_i), .srst_i(srst_i),
        .req_valid_i(req_valid_i), .req_cmd_i(req_cmd_i),
        .req_bank_i(req_bank_i), .req_ap_i(req_ap_i),
        .req_addr_i(req_addr_i), .cfg_precharge_period_i(t_short),
        .cfg_activate_to_access_delay_i(t_short),
        .cfg_bank_refresh_period_i(t_short),
        .cfg_all_bank_refresh_period_i(t_short),
        .cfg_mode_read_period_i(t_short),
        .cfg_mode_write_period_i(t_short), .cfg_burst_cycles_i(t_burst),
        .req_done_o(req_done_o), .req_refused_o(req_refused_o),
        .init_done_o(init_done_o), .dev_cke_o(dev_cke_o),
        .dev_cmd_o(dev_cmd_o), .dev_bank_o(dev_bank_o),
        .dev_ap_o(dev_ap_o), .dev_addr_o(dev_addr_o));
    dbsr_dev_model u_dev (.clk_i(clk_i), .srst_i(srst_i),
        .cke_i(dev_cke_o), .cmd_i(dev_cmd_o), .bank_i(dev_bank_o),
        .ap_i(dev_ap_o), .viol_o(viol));
    initial forever #5 clk_i = ~clk_i;
    ////////////////////////////////////////////////////////////////////////
    task automatic close_out();
        $display("compares %0d mismatches %0d", cmp_count, err_count);
        if (err_count == 0 && cmp_count > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask
    always @(posedge clk_i)
    begin
        cycles++;
        if (cycles == 3000)
        begin
            err_count++;
            close_out();
        end
    end
    task automatic idle(input int n);
        repeat (n) @(posedge clk_i);
    endtask
    // One request, answer judged the cycle after it is taken
    task automatic req(input dbsr_pkg::dbsr_cmd_t c, input logic [2:0] b,
                       input logic ap, input logic ok);
        @(posedge clk_i);
        #1;
        req_valid_i = 1'b1;
        req_cmd_i = c;
        req_bank_i = b;
        req_ap_i = ap;
        req_addr_i = {13'h0a5a, b};
        @(posedge clk_i);
        #1;
        req_valid_i = 1'b0;
        `CHK(req_done_o, ok)
        `CHK(dev_cmd_o, ok ? c : dbsr_pkg::CMD_NOP)
        `CHK(req_refused_o, !ok)
        `CHK(dev_bank_o, ok ? b : 3'h0)
        `CHK(dev_ap_o, ok && ap)
        `CHK(dev_addr_o, ok ? {13'h0a5a, b} : 16'h0000)
    endtask
    ////////////////////////////////////////////////////////////////////////
    task automatic t_init();
        req(dbsr_pkg::CMD_ACT, 3'h1, 1'b0, 1'b0);
        req(dbsr_pkg::CMD_MRR, 3'h0, 1'b0, 1'b0);
        idle(2);
        req(dbsr_pkg::CMD_MRR, 3'h0, 1'b0, 1'b1);
        for (int i = 0; i < 100 && init_done_o !== 1'b1; i++) idle(1);
        `CHK(init_done_o, 1'b1)
        $display("init test done");
    endtask
    task automatic t_access();
        req(dbsr_pkg::CMD_ACT, 3'h2, 1'b0, 1'b1);
        req(dbsr_pkg::CMD_RD, 3'h2, 1'b0, 1'b0);
        idle(5);
        req(dbsr_pkg::CMD_RD, 3'h2, 1'b0, 1'b1);
        req(dbsr_pkg::CMD_WR, 3'h2, 1'b0, 1'b0);
        req(dbsr_pkg::CMD_BST, 3'h0, 1'b0, 1'b1);
        req(dbsr_pkg::CMD_WR, 3'h2, 1'b0, 1'b1);
        req(dbsr_pkg::CMD_RD, 3'h2, 1'b0, 1'b0);
        req(dbsr_pkg::CMD_ACT, 3'h3, 1'b0, 1'b1);
        idle(10);
        req(dbsr_pkg::CMD_PRE, 3'h2, 1'b0, 1'b1);
        req(dbsr_pkg::CMD_ACT, 3'h2, 1'b0, 1'b0);
        req(dbsr_pkg::CMD_PRE, 3'h5, 1'b0, 1'b1);
        req(dbsr_pkg::CMD_ACT, 3'h5, 1'b0, 1'b0);
        idle(6);
        req(dbsr_pkg::CMD_ACT, 3'h2, 1'b0, 1'b1);
        $display("access test done");
    endtask
    task automatic t_hold();
        idle(6);
        req(dbsr_pkg::CMD_PREA, 3'h0, 1'b0, 1'b1);
        req(dbsr_pkg::CMD_ACT, 3'h1, 1'b0, 1'b0);
        idle(6);
        req(dbsr_pkg::CMD_REFAB, 3'h0, 1'b0, 1'b1);
        req(dbsr_pkg::CMD_MRR, 3'h0, 1'b0, 1'b0);
        idle(6);
        req(dbsr_pkg::CMD_MRW, 3'h0, 1'b0, 1'b1);
        req(dbsr_pkg::CMD_ACT, 3'h1, 1'b0, 1'b0);
        idle(6);
        req(dbsr_pkg::CMD_REFPB, 3'h4, 1'b0, 1'b1);
        req(dbsr_pkg::CMD_ACT, 3'h4, 1'b0, 1'b0);
        idle(6);
        req(dbsr_pkg::CMD_ACT, 3'h6, 1'b0, 1'b1);
        idle(6);
        req(dbsr_pkg::CMD_RD, 3'h6, 1'b1, 1'b1);
        req(dbsr_pkg::CMD_RD, 3'h6, 1'b0, 1'b0);
        idle(20);
        req(dbsr_pkg::CMD_ACT, 3'h6, 1'b0, 1'b1);
        $display("hold test done");
    endtask
    initial
    begin
        idle(8);
        #1;
        srst_i = 1'b0;
        t_init();
        t_access();
        t_hold();
        idle(4);
        `CHK(viol, 0)
        close_out();
    end
endmodule
